// ---- dv/mac_frame_statistics_counters_bench.sv ----
// Self-checking bench: random frame status, counter readback over AHB-Lite.
// Assumes the slave answers via hreadyout and the MAC model drives status.
`timescale 1ns/1ps
module mac_frame_statistics_counters_bench
  import mfsc_pkg::*;
;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'b00;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic hreadyout, hresp, rsp, tx_done, tx_underrun, tx_retry_exceeded, tx_deferred;
  logic tx_late_collision, rx_done, rx_odd_bits, rx_crc_bad, rx_symbol_err;
  logic rx_addr_match, rx_copied;
  logic [31:0] hrdata, q, cfg, ctl;
  logic [4:0] tx_collisions;
  logic [13:0] rx_len;
  int bad_count = 0;
  int n_checks = 0;
  int exp_cnt [MFSC_NCNT] = '{default: 0};
  always #50 hclk = ~hclk;
  mfsc_stats mfsc_stats_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'b010), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_done,
    .tx_collisions, .tx_underrun, .tx_retry_exceeded, .tx_deferred, .tx_late_collision,
    .rx_done, .rx_len, .rx_odd_bits, .rx_crc_bad, .rx_symbol_err, .rx_addr_match, .rx_copied);
  mfsc_mac_model mfsc_mac_model_inst (.hclk, .tx_done, .tx_collisions, .tx_underrun,
    .tx_retry_exceeded, .tx_deferred, .tx_late_collision, .rx_done, .rx_len, .rx_odd_bits,
    .rx_crc_bad, .rx_symbol_err, .rx_addr_match, .rx_copied);
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] want, input string what);
    n_checks++;
    if (got !== want) begin
      bad_count++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, want);
    end
  endtask
  // Address phase, then data phase; each ends on an edge with hready high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
    rsp = hresp;
  endtask
  function automatic logic [6:0] incs(logic dt, logic [8:0] t, logic dr, logic [18:0] r);
    logic v, bad;
    logic [13:0] mx;
    mx = cfg[MFSC_CFG_JUMBO_BIT] ? MFSC_LEN_MAX_JUMBO :
      cfg[MFSC_CFG_BIG_BIT] ? MFSC_LEN_MAX_BIG : MFSC_LEN_MAX_STD;
    v = dr && ctl[MFSC_CTRL_RXEN_BIT] && r[18:5] >= MFSC_LEN_MIN && r[18:5] <= mx;
    bad = r[3] | r[2];
    incs[0] = dt && !t[3] && !t[2] && t[8:4] >= 5'd2 && t[8:4] <= 5'd15;
    incs[1] = v && !bad && r[1] && r[0];
    incs[2] = v && !r[4] && bad;
    incs[3] = v && r[4] && bad;
    incs[4] = dt && !t[3] && t[1] && t[8:4] == 5'd0 && !t[0];
    incs[5] = dt && !t[3] && t[0];
    incs[6] = dt && !t[3] && t[2];
  endfunction
  task automatic rand_frame();
    logic [4:0] c;
    logic [13:0] ln;
    logic cb, s, dt, dr;
    logic [8:0] t;
    logic [18:0] r;
    int lens [8] = '{63, 64, 1518, 1519, 1536, 1537, 10240, 10241};
    logic [6:0] e;
    c = 5'($urandom_range(16));
    t = {c, $urandom_range(5) == 0, c == 5'd16, 1'($urandom), c != 0 && $urandom_range(3) == 0};
    ln = $urandom_range(9) > 7 ? 14'($urandom_range(1500, 64)) : 14'(lens[$urandom_range(7)]);
    cb = 1'($urandom);
    s = $urandom_range(5) == 0;
    r = {ln, (cb | s) & 1'($urandom), cb, s, 1'($urandom), $urandom_range(4) != 0};
    dt = 1'($urandom);
    dr = 1'($urandom);
    mfsc_mac_model_inst.frame(dt, t, dr, r);
    e = incs(dt, t, dr, r);
    for (int i = 0; i < MFSC_NCNT; i++)
      if (e[i] && exp_cnt[i] < (1 << MFSC_CNT_W[i]) - 1) exp_cnt[i]++;
  endtask
  task automatic read_all(input string what);
    for (int i = 0; i < MFSC_NCNT; i++) begin
      bus(1'b0, MFSC_OFS_CNT_BASE + 8'(4 * i), 32'h00000000);
      cmp(q, 32'(exp_cnt[i]), what);
      exp_cnt[i] = 0;
    end
    $display("test %s done", what);
  endtask
  initial begin
    void'($urandom(32'h6F98));
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    read_all("reset");
    for (int k = 0; k < 6; k++) begin
      cfg = {23'h000000, 1'(k >> 1), 4'h0, 1'(k), 3'h0};
      ctl = {29'h00000000, 1'(k != 1), 2'h0};
      bus(1'b1, MFSC_OFS_CFG, cfg);
      bus(1'b1, MFSC_OFS_CTRL, ctl);
      repeat (40) rand_frame();
      read_all("random batch");
    end
    ctl = 32'h00000084;
    bus(1'b1, MFSC_OFS_CTRL, ctl);
    bus(1'b1, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_CRC), 32'hFFFFFFFE);
    bus(1'b1, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_EXCESS), 32'h000000FE);
    repeat (2) mfsc_mac_model_inst.frame(1'b1, 9'h104, 1'b1, {14'h0064, 5'h08});
    bus(1'b0, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_CRC), 32'h00000000);
    cmp(q, 32'h000000FF, "saturation");
    bus(1'b0, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_CRC), 32'h00000000);
    cmp(q, 32'h00000000, "clear on read");
    bus(1'b0, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_EXCESS), 32'h00000000);
    cmp(q, 32'h000000FF, "excess saturation");
    ctl = 32'h00000004;
    bus(1'b1, MFSC_OFS_CTRL, ctl);
    bus(1'b1, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_LATE), 32'h00000055);
    bus(1'b0, MFSC_OFS_CNT_BASE + 8'(4 * MFSC_IX_LATE), 32'h00000000);
    cmp(q, 32'h00000000, "locked write");
    cmp({31'h00000000, rsp}, 32'h00000000, "locked write response");
    bus(1'b0, 8'h3C, 32'h00000000);
    cmp(q, 32'h00000000, "unmapped read");
    $display("test corner done");
    end_of_test();
  end
  initial begin
    #5000000;
    bad_count++;
    end_of_test();
  end
endmodule

// ---- dv/mfsc_mac_model.sv ----
// MAC frame status source for the statistics bank.
// Assumes frame() is called just after a rising edge of hclk.
`timescale 1ns/1ps
module mfsc_mac_model (
  input wire logic hclk,
  output logic tx_done,
  output logic [4:0] tx_collisions,
  output logic tx_underrun,
  output logic tx_retry_exceeded,
  output logic tx_deferred,
  output logic tx_late_collision,
  output logic rx_done,
  output logic [13:0] rx_len,
  output logic rx_odd_bits,
  output logic rx_crc_bad,
  output logic rx_symbol_err,
  output logic rx_addr_match,
  output logic rx_copied
);
  logic [8:0] tf = 9'h000;
  logic [18:0] rf = 19'h00000;
  assign {tx_collisions, tx_underrun, tx_retry_exceeded, tx_deferred, tx_late_collision} = tf;
  assign {rx_len, rx_odd_bits, rx_crc_bad, rx_symbol_err, rx_addr_match, rx_copied} = rf;
  initial begin
    tx_done = 1'b0;
    rx_done = 1'b0;
  end
  // Stale status fields are inverted, not held
  task automatic frame(input logic dt, input logic [8:0] t, input logic dr, input logic [18:0] r);
    tx_done <= dt;
    rx_done <= dr;
    tf <= t;
    rf <= r;
    @(posedge hclk);
    tx_done <= 1'b0;
    rx_done <= 1'b0;
    tf <= ~t;
    rf <= ~r;
    @(posedge hclk);
  endtask
endmodule

// ---- src/mfsc_pkg.sv ----
// Shared constants of the frame statistics counter bank.
// Assumes a single 10 MHz bus clock and a 32-bit AHB-Lite register port.
package mfsc_pkg;
  // Register map, byte addresses
  localparam logic [7:0] MFSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] MFSC_OFS_CFG = 8'h04;
  localparam logic [7:0] MFSC_OFS_CNT_BASE = 8'h10;
  localparam int MFSC_NCNT = 7;
  // Counter indices
  localparam int MFSC_IX_MULTI = 0;
  localparam int MFSC_IX_GOOD = 1;
  localparam int MFSC_IX_CRC = 2;
  localparam int MFSC_IX_ALIGN = 3;
  localparam int MFSC_IX_DEFER = 4;
  localparam int MFSC_IX_LATE = 5;
  localparam int MFSC_IX_EXCESS = 6;
  localparam int MFSC_CNT_W [MFSC_NCNT] = '{16, 24, 8, 8, 16, 8, 8};
  localparam logic [23:0] MFSC_CNT_RST = 24'h000000;
  // Control and configuration fields
  localparam int MFSC_CTRL_RXEN_BIT = 2;
  localparam int MFSC_CTRL_STATS_WE_BIT = 7;
  localparam int MFSC_CFG_JUMBO_BIT = 3;
  localparam int MFSC_CFG_BIG_BIT = 8;
  localparam logic [31:0] MFSC_CTRL_RST = 32'h00000000;
  localparam logic [31:0] MFSC_CFG_RST = 32'h00000000;
  localparam logic [31:0] MFSC_CTRL_MASK = 32'h00000084;
  localparam logic [31:0] MFSC_CFG_MASK = 32'h00000108;
  // Frame length limits in bytes
  localparam logic [13:0] MFSC_LEN_MIN = 14'h0040;
  localparam logic [13:0] MFSC_LEN_MAX_STD = 14'h05EE;
  localparam logic [13:0] MFSC_LEN_MAX_BIG = 14'h0600;
  localparam logic [13:0] MFSC_LEN_MAX_JUMBO = 14'h2800;
  // Collision thresholds
  localparam logic [4:0] MFSC_COLL_MULTI_MIN = 5'h02;
  localparam logic [4:0] MFSC_COLL_MULTI_MAX = 5'h0F;
endpackage

// ---- src/mfsc_stats.sv ----
// Frame statistics counters with an AHB-Lite register slave.
// Assumes per-frame status pulses from MAC logic on the same clock.
// Contract
// - 16-bit count of frames with 2..15 collisions
// - Multi-collision counted only without underrun or retry-limit
// - 24-bit count of good received frames
// - Good frame needs address match and full copy
// - Good frame has no CRC, alignment, symbol error
// - Valid length 64..1518 bytes by default
// - Limit 1536 with big bit, 10240 with jumbo
// - 8-bit count of whole-byte valid frames, bad CRC
// - Symbol error in whole-byte valid frame counts too
// - 8-bit count of odd-bit valid frames, bad CRC
// - Symbol error in odd-bit valid frame counts too
// - 16-bit count of frames deferred on first attempt
// - Deferral ignores collided or underrun frames
// - 8-bit count of collisions after slot time
// - Late collision also counted as ordinary collision
// - Counters clear on read, saturate at all ones
// - Counter writes only while write-enable bit set
// - Receive counters move only while receive enabled
// - 8-bit count of frames dropped after 16 collisions
`timescale 1ns/1ps
module mfsc_stats
  import mfsc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic tx_done,
  input wire logic [4:0] tx_collisions,
  input wire logic tx_underrun,
  input wire logic tx_retry_exceeded,
  input wire logic tx_deferred,
  input wire logic tx_late_collision,
  input wire logic rx_done,
  input wire logic [13:0] rx_len,
  input wire logic rx_odd_bits,
  input wire logic rx_crc_bad,
  input wire logic rx_symbol_err,
  input wire logic rx_addr_match,
  input wire logic rx_copied
);

  function automatic logic [23:0] mfsc_mask(input int w);
    mfsc_mask = 24'hFFFFFF >> (24 - w);
  endfunction

  function automatic logic [23:0] mfsc_sat_inc(input logic [23:0] v, input int w);
    logic [23:0] m;
    m = mfsc_mask(w);
    mfsc_sat_inc = (v == m) ? v : ((v + 24'h000001) & m);
  endfunction

  function automatic logic [7:0] mfsc_cnt_ofs(input int i);
    mfsc_cnt_ofs = MFSC_OFS_CNT_BASE + 8'(4 * i);
  endfunction

  logic [31:0] network_control_reg;
  logic [31:0] network_config_reg;
  logic [23:0] cnt [MFSC_NCNT];
  logic dp_write;
  logic [7:0] dp_addr;

  // Bus decode
  wire addr_ok = hsel && htrans[1] && hready;
  wire rd_take = addr_ok && !hwrite;
  wire [7:0] a_addr = haddr[7:0];
  wire stats_write_enable = network_control_reg[MFSC_CTRL_STATS_WE_BIT];
  wire rx_enable = network_control_reg[MFSC_CTRL_RXEN_BIT];
  wire big_frame_enable = network_config_reg[MFSC_CFG_BIG_BIT];
  wire jumbo_frame_enable = network_config_reg[MFSC_CFG_JUMBO_BIT];
  wire wr_ctrl = dp_write && (dp_addr == MFSC_OFS_CTRL);
  wire wr_cfg = dp_write && (dp_addr == MFSC_OFS_CFG);

  // Transmit event decode
  wire tx_ok = tx_done && !tx_underrun && !tx_retry_exceeded;
  wire multi_collision_frames = tx_ok && (tx_collisions >= MFSC_COLL_MULTI_MIN)
    && (tx_collisions <= MFSC_COLL_MULTI_MAX);
  wire deferred_frames = tx_done && tx_deferred && !tx_underrun
    && (tx_collisions == 5'h00) && !tx_late_collision;
  // Late collision stays in tx_collisions for other statistics
  wire late_collisions = tx_done && !tx_underrun && tx_late_collision;
  wire excess_collisions = tx_done && !tx_underrun && tx_retry_exceeded;

  // Receive event decode
  wire [13:0] len_max = jumbo_frame_enable ? MFSC_LEN_MAX_JUMBO :
    (big_frame_enable ? MFSC_LEN_MAX_BIG : MFSC_LEN_MAX_STD);
  wire len_ok = (rx_len >= MFSC_LEN_MIN) && (rx_len <= len_max);
  wire rx_ev = rx_done && rx_enable && len_ok;
  wire good_frames_received = rx_ev && rx_addr_match && rx_copied
    && !rx_crc_bad && !rx_odd_bits && !rx_symbol_err;
  wire crc_errors = rx_ev && !rx_odd_bits && (rx_crc_bad || rx_symbol_err);
  wire align_errors = rx_ev && rx_odd_bits && (rx_crc_bad || rx_symbol_err);

  wire [MFSC_NCNT-1:0] inc = {excess_collisions, late_collisions, deferred_frames,
    align_errors, crc_errors, good_frames_received, multi_collision_frames};

  logic [MFSC_NCNT-1:0] rd_clr;
  logic [MFSC_NCNT-1:0] wr_cnt;
  logic [23:0] next_cnt [MFSC_NCNT];
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h00000000;
    if (a_addr == MFSC_OFS_CTRL) begin
      next_rdata = network_control_reg;
    end else if (a_addr == MFSC_OFS_CFG) begin
      next_rdata = network_config_reg;
    end
    for (int i = 0; i < MFSC_NCNT; i++) begin
      rd_clr[i] = rd_take && (a_addr == mfsc_cnt_ofs(i));
      wr_cnt[i] = dp_write && stats_write_enable && (dp_addr == mfsc_cnt_ofs(i));
      if (a_addr == mfsc_cnt_ofs(i)) begin
        next_rdata = {8'h00, cnt[i]};
      end
      next_cnt[i] = wr_cnt[i] ? (hwdata[23:0] & mfsc_mask(MFSC_CNT_W[i])) :
        (rd_clr[i] ? MFSC_CNT_RST : cnt[i]);
      // An event in the clearing cycle is kept
      if (inc[i]) begin
        next_cnt[i] = mfsc_sat_inc(next_cnt[i], MFSC_CNT_W[i]);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h00000000;
    end else begin
      dp_write <= addr_ok && hwrite;
      dp_addr <= a_addr;
      hrdata <= rd_take ? next_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      network_control_reg <= MFSC_CTRL_RST;
      network_config_reg <= MFSC_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        network_control_reg <= hwdata & MFSC_CTRL_MASK;
      end
      if (wr_cfg) begin
        network_config_reg <= hwdata & MFSC_CFG_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MFSC_NCNT; i++) begin
        cnt[i] <= MFSC_CNT_RST;
      end
    end else begin
      for (int i = 0; i < MFSC_NCNT; i++) begin
        cnt[i] <= next_cnt[i];
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  wire [MFSC_NCNT-1:0] touch = rd_clr | wr_cnt;

  chk_multi_count: assert property (
    multi_collision_frames && !touch[MFSC_IX_MULTI] && (cnt[MFSC_IX_MULTI] != 24'h00FFFF)
    |=> cnt[MFSC_IX_MULTI] == $past(cnt[MFSC_IX_MULTI]) + 24'h000001)
    else $error("multi-collision counter missed a frame");

  chk_multi_block: assert property (
    tx_done && (tx_underrun || tx_retry_exceeded) && !touch[MFSC_IX_MULTI]
    |=> $stable(cnt[MFSC_IX_MULTI]))
    else $error("multi-collision counted a failed frame");

  chk_good_rxen: assert property (
    !rx_enable && !touch[MFSC_IX_GOOD] |=> $stable(cnt[MFSC_IX_GOOD]))
    else $error("good-receive counter moved while receive disabled");

  chk_good_count: assert property (
    rx_done && rx_enable && len_ok && rx_addr_match && rx_copied && !rx_crc_bad
    && !rx_odd_bits && !rx_symbol_err && !touch[MFSC_IX_GOOD]
    && (cnt[MFSC_IX_GOOD] != 24'hFFFFFF)
    |=> cnt[MFSC_IX_GOOD] == $past(cnt[MFSC_IX_GOOD]) + 24'h000001)
    else $error("good-receive counter missed a frame");

  chk_crc_count: assert property (
    rx_done && rx_enable && !rx_odd_bits && rx_crc_bad && (rx_len == MFSC_LEN_MAX_STD)
    && !touch[MFSC_IX_CRC] && (cnt[MFSC_IX_CRC] != 24'h0000FF)
    |=> cnt[MFSC_IX_CRC] == $past(cnt[MFSC_IX_CRC]) + 24'h000001)
    else $error("crc counter missed a frame");

  chk_align_len: assert property (
    rx_done && rx_odd_bits && (rx_len < MFSC_LEN_MIN) && !touch[MFSC_IX_ALIGN]
    |=> $stable(cnt[MFSC_IX_ALIGN]))
    else $error("alignment counter took a short frame");

  chk_defer_block: assert property (
    tx_done && (tx_collisions != 5'd0) && !touch[MFSC_IX_DEFER]
    |=> $stable(cnt[MFSC_IX_DEFER]))
    else $error("deferral counter took a collided frame");

  chk_late_count: assert property (
    tx_done && tx_late_collision && !tx_underrun && !touch[MFSC_IX_LATE]
    && (cnt[MFSC_IX_LATE] != 24'h0000FF)
    |=> cnt[MFSC_IX_LATE] == $past(cnt[MFSC_IX_LATE]) + 24'h000001)
    else $error("late collision counter missed a frame");

  chk_excess_sat: assert property (
    (cnt[MFSC_IX_EXCESS] == 24'h0000FF) && !touch[MFSC_IX_EXCESS]
    |=> cnt[MFSC_IX_EXCESS] == 24'h0000FF)
    else $error("excessive collision counter wrapped");

  chk_read_clear: assert property (
    rd_take && (a_addr == mfsc_cnt_ofs(MFSC_IX_DEFER)) && !inc[MFSC_IX_DEFER]
    && !wr_cnt[MFSC_IX_DEFER]
    |=> (cnt[MFSC_IX_DEFER] == 24'h000000) && (hrdata[23:0] == $past(cnt[MFSC_IX_DEFER])))
    else $error("read did not clear the deferral counter");

  chk_write_gate: assert property (
    dp_write && !stats_write_enable && (dp_addr == mfsc_cnt_ofs(MFSC_IX_LATE))
    && !inc[MFSC_IX_LATE] && !rd_clr[MFSC_IX_LATE]
    |=> $stable(cnt[MFSC_IX_LATE]))
    else $error("counter written while write-enable clear");

  chk_upper_zero: assert property (
    (cnt[MFSC_IX_CRC][23:8] == 16'h0000) && (cnt[MFSC_IX_MULTI][23:16] == 8'h00))
    else $error("counter bits above field width set");

  // Transmit checks
  chk_defer_count: assert property (
    tx_done && tx_deferred && !tx_underrun && (tx_collisions == 5'h00) && !tx_late_collision
    && !touch[MFSC_IX_DEFER] && (cnt[MFSC_IX_DEFER] != 24'h00FFFF)
    |=> cnt[MFSC_IX_DEFER] == $past(cnt[MFSC_IX_DEFER]) + 24'h000001)
    else $error("deferral counter missed a frame");

  chk_defer_underrun: assert property (
    tx_done && tx_underrun && !touch[MFSC_IX_DEFER] |=> $stable(cnt[MFSC_IX_DEFER]))
    else $error("deferral counter took an underrun frame");

  chk_late_multi: assert property (
    tx_done && tx_late_collision && !tx_underrun && !tx_retry_exceeded
    && (tx_collisions >= MFSC_COLL_MULTI_MIN) && (tx_collisions <= MFSC_COLL_MULTI_MAX)
    && !touch[MFSC_IX_MULTI] && (cnt[MFSC_IX_MULTI] != 24'h00FFFF)
    |=> cnt[MFSC_IX_MULTI] == $past(cnt[MFSC_IX_MULTI]) + 24'h000001)
    else $error("late collision frame missing from collision statistics");

  chk_late_underrun: assert property (
    tx_done && tx_underrun && !touch[MFSC_IX_LATE] |=> $stable(cnt[MFSC_IX_LATE]))
    else $error("late collision counter took an underrun frame");

  chk_excess_count: assert property (
    tx_done && tx_retry_exceeded && !tx_underrun && !touch[MFSC_IX_EXCESS]
    && (cnt[MFSC_IX_EXCESS] != 24'h0000FF)
    |=> cnt[MFSC_IX_EXCESS] == $past(cnt[MFSC_IX_EXCESS]) + 24'h000001)
    else $error("excessive collision counter missed a frame");

  chk_excess_underrun: assert property (
    tx_done && tx_underrun && !touch[MFSC_IX_EXCESS] |=> $stable(cnt[MFSC_IX_EXCESS]))
    else $error("excessive collision counter took an underrun frame");

  // Receive, counter access and control register checks
  chk_good_addr: assert property (
    rx_done && !(rx_addr_match && rx_copied) && !touch[MFSC_IX_GOOD]
    |=> $stable(cnt[MFSC_IX_GOOD]))
    else $error("good-receive counter took an unmatched frame");

  chk_good_error: assert property (
    rx_done && (rx_crc_bad || rx_odd_bits || rx_symbol_err) && !touch[MFSC_IX_GOOD]
    |=> $stable(cnt[MFSC_IX_GOOD]))
    else $error("good-receive counter took a frame with errors");

  chk_len_long: assert property (
    rx_done && !jumbo_frame_enable && !big_frame_enable && (rx_len > MFSC_LEN_MAX_STD)
    && !touch[MFSC_IX_CRC] |=> $stable(cnt[MFSC_IX_CRC]))
    else $error("crc counter took an overlong frame");

  chk_len_big: assert property (
    rx_done && rx_enable && big_frame_enable && !jumbo_frame_enable && !rx_odd_bits
    && rx_crc_bad && (rx_len == MFSC_LEN_MAX_BIG) && !touch[MFSC_IX_CRC]
    && (cnt[MFSC_IX_CRC] != 24'h0000FF)
    |=> cnt[MFSC_IX_CRC] == $past(cnt[MFSC_IX_CRC]) + 24'h000001)
    else $error("crc counter dropped a big frame");

  chk_len_jumbo: assert property (
    rx_done && (rx_len > MFSC_LEN_MAX_JUMBO) && !touch[MFSC_IX_ALIGN]
    |=> $stable(cnt[MFSC_IX_ALIGN]))
    else $error("alignment counter took a frame above the jumbo limit");

  chk_crc_symbol: assert property (
    rx_done && rx_enable && len_ok && !rx_odd_bits && rx_symbol_err && !touch[MFSC_IX_CRC]
    && (cnt[MFSC_IX_CRC] != 24'h0000FF)
    |=> cnt[MFSC_IX_CRC] == $past(cnt[MFSC_IX_CRC]) + 24'h000001)
    else $error("crc counter missed a symbol error");

  chk_align_count: assert property (
    rx_done && rx_enable && len_ok && rx_odd_bits && rx_crc_bad && !touch[MFSC_IX_ALIGN]
    && (cnt[MFSC_IX_ALIGN] != 24'h0000FF)
    |=> cnt[MFSC_IX_ALIGN] == $past(cnt[MFSC_IX_ALIGN]) + 24'h000001)
    else $error("alignment counter missed a frame");

  chk_align_symbol: assert property (
    rx_done && rx_enable && len_ok && rx_odd_bits && rx_symbol_err && !touch[MFSC_IX_ALIGN]
    && (cnt[MFSC_IX_ALIGN] != 24'h0000FF)
    |=> cnt[MFSC_IX_ALIGN] == $past(cnt[MFSC_IX_ALIGN]) + 24'h000001)
    else $error("alignment counter missed a symbol error");

  chk_read_good: assert property (
    rd_take && (a_addr == mfsc_cnt_ofs(MFSC_IX_GOOD))
    |=> hrdata == {8'h00, $past(cnt[MFSC_IX_GOOD])})
    else $error("good-receive readback wrong");

  chk_write_mask: assert property (
    dp_write && stats_write_enable && (dp_addr == mfsc_cnt_ofs(MFSC_IX_CRC))
    && !inc[MFSC_IX_CRC]
    |=> cnt[MFSC_IX_CRC] == {16'h0000, $past(hwdata[7:0])})
    else $error("counter write kept bits above its field");

  chk_ctrl_mask: assert property (
    wr_ctrl |=> network_control_reg == ($past(hwdata) & MFSC_CTRL_MASK))
    else $error("control register kept unmapped bits");

endmodule
